// ---- external_memory_bus_pins.sv ----
// External memory bus pin controller: selects, strobes, address and data
`timescale 1ns/1ps
module external_memory_bus_pins
    import ext_bus_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire ext_bus_pkg::bus_req_type req,
    output ext_bus_pkg::bus_rsp_type rsp,
    output logic req_ready,
    input wire logic [ext_bus_pkg::ADDR_W-1:0] boot_base,
    input wire logic swap,
    input wire ext_bus_pkg::select_cfg_type [ext_bus_pkg::NUM_SEL-1:0] sel_cfg,
    input wire logic clk_out_enable,
    output logic boot_is_16bit,
    input wire logic wait_or_boot_width_input,
    output logic boot_region_select_n,
    output logic [ext_bus_pkg::NUM_SEL-1:0] select_or_row_strobe_n,
    output logic write_strobe_n,
    output logic output_enable_n,
    output logic low_lane_enable_column_strobe_n,
    output logic high_lane_enable_column_strobe_n,
    output logic buffered_cpu_clock_pin,
    output logic [ext_bus_pkg::PIN_ADDR_W-1:0] address_outputs,
    input wire logic [ext_bus_pkg::DATA_W-1:0] data_lines_in,
    output logic [ext_bus_pkg::DATA_W-1:0] data_lines_out,
    output logic data_lines_oe_n
);
    import ext_bus_pkg::*;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_GEN = 5'h02,
        ST_ROW = 5'h04,
        ST_COL = 5'h08,
        ST_END = 5'h10
    } state_type;

    // ==========================================================
    // Region decode
    logic boot_hit;
    logic [NUM_SEL-1:0] sel_hit;
    logic [ADDR_W-1:0] boot_base_eff;

    // Boot base taken straight from the boot_base port with no reset value applied here; BOOT_BASE_RESET is not used
    assign boot_base_eff = boot_base;
    region_decode u_decode (
        .addr(req.addr),
        .boot_base(boot_base_eff),
        .boot_mask(BOOT_MASK_RESET),
        .swap(swap),
        .cfg(sel_cfg),
        .boot_hit(boot_hit),
        .sel_hit(sel_hit)
    );

    // ==========================================================
    // Clock pin
    clock_out_gate u_clk (
        .clk_sys(clk_sys),
        .rst(rst),
        .enable(clk_out_enable),
        .clk_pin(buffered_cpu_clock_pin)
    );

    // ==========================================================
    // Cycle state
    state_type state;
    state_type next_state;
    logic cyc_write;
    logic next_cyc_write;
    logic [ADDR_W-1:0] cyc_addr;
    logic [ADDR_W-1:0] next_cyc_addr;
    logic [1:0] cyc_lanes;
    logic [1:0] next_cyc_lanes;
    logic [DATA_W-1:0] cyc_wdata;
    logic [DATA_W-1:0] next_cyc_wdata;
    logic cyc_boot;
    logic next_cyc_boot;
    logic [NUM_SEL-1:0] cyc_sel;
    logic [NUM_SEL-1:0] next_cyc_sel;
    logic cyc_dram;
    logic next_cyc_dram;
    logic width_seen;
    logic next_width_seen;
    logic next_boot_is_16bit;
    logic waiting;

    assign waiting = wait_or_boot_width_input;

    always_comb begin
        logic hit_dram;
        hit_dram = 1'b0;
        for (int i = 0; i < NUM_SEL; i++) begin
            if (sel_hit[i] && sel_cfg[i].row_strobe_mode) begin
                hit_dram = 1'b1;
            end
        end
        next_state = state;
        next_cyc_write = cyc_write;
        next_cyc_addr = cyc_addr;
        next_cyc_lanes = cyc_lanes;
        next_cyc_wdata = cyc_wdata;
        next_cyc_boot = cyc_boot;
        next_cyc_sel = cyc_sel;
        next_cyc_dram = cyc_dram;
        next_width_seen = 1'b1;
        next_boot_is_16bit = boot_is_16bit;
        // Width latched on the first edge after reset release
        if (!width_seen) begin
            next_boot_is_16bit = wait_or_boot_width_input;
        end
        unique case (state)
            ST_IDLE: begin
                if (req.valid && width_seen) begin
                    next_cyc_write = req.write;
                    next_cyc_addr = req.addr;
                    next_cyc_lanes = req.lanes;
                    next_cyc_wdata = req.wdata;
                    next_cyc_boot = boot_hit;
                    next_cyc_sel = sel_hit;
                    next_cyc_dram = hit_dram;
                    next_state = hit_dram ? ST_ROW : ST_GEN;
                end
            end
            ST_GEN: begin
                if (!waiting) begin
                    next_state = ST_END;
                end
            end
            ST_ROW: begin
                next_state = ST_COL;
            end
            ST_COL: begin
                if (!waiting) begin
                    next_state = ST_END;
                end
            end
            ST_END: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            cyc_write <= 1'b0;
            cyc_addr <= '0;
            cyc_lanes <= '0;
            cyc_wdata <= '0;
            cyc_boot <= 1'b0;
            cyc_sel <= '0;
            cyc_dram <= 1'b0;
            width_seen <= 1'b0;
            boot_is_16bit <= 1'b0;
        end else begin
            state <= next_state;
            cyc_write <= next_cyc_write;
            cyc_addr <= next_cyc_addr;
            cyc_lanes <= next_cyc_lanes;
            cyc_wdata <= next_cyc_wdata;
            cyc_boot <= next_cyc_boot;
            cyc_sel <= next_cyc_sel;
            cyc_dram <= next_cyc_dram;
            width_seen <= next_width_seen;
            boot_is_16bit <= next_boot_is_16bit;
        end
    end

    // ==========================================================
    // Pin drive, all registered
    logic next_boot_n;
    logic [NUM_SEL-1:0] next_sel_n;
    logic next_we_n;
    logic next_oe_n;
    logic next_ble_n;
    logic next_bhe_n;
    logic [PIN_ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_dout;
    logic next_doe_n;
    bus_rsp_type next_rsp;
    logic next_ready;

    always_comb begin
        logic active;
        logic strobe;
        active = (next_state == ST_GEN) || (next_state == ST_ROW) ||
            (next_state == ST_COL);
        strobe = (next_state == ST_GEN) || (next_state == ST_COL);
        next_boot_n = ~(active && next_cyc_boot);
        next_sel_n = ~({NUM_SEL{active}} & next_cyc_sel);
        next_we_n = ~(strobe && next_cyc_write);
        next_oe_n = ~(strobe && !next_cyc_write);
        next_ble_n = ~(strobe && next_cyc_lanes[0]);
        next_bhe_n = ~(strobe && next_cyc_lanes[1]);
        next_addr = next_cyc_addr[PIN_ADDR_W-1:0];
        if (next_cyc_dram) begin
            next_addr = '0;
            if (next_state == ST_COL) begin
                next_addr[DRAM_ADDR_MSB:DRAM_ADDR_LSB] = next_cyc_addr[
                    ADDR_W-1-DRAM_COL_SHIFT -: DRAM_COL_SHIFT];
            end else begin
                next_addr[DRAM_ADDR_MSB:DRAM_ADDR_LSB] =
                    next_cyc_addr[ADDR_W-1 -: DRAM_COL_SHIFT];
            end
        end
        next_dout = next_cyc_wdata;
        next_doe_n = ~(active && next_cyc_write);
        next_rsp.done = (state != ST_IDLE) && (next_state == ST_END);
        next_rsp.rdata = next_rsp.done ? data_lines_in : rsp.rdata;
        next_ready = (next_state == ST_IDLE) && next_width_seen;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            boot_region_select_n <= 1'b1;
            select_or_row_strobe_n <= '1;
            write_strobe_n <= 1'b1;
            output_enable_n <= 1'b1;
            low_lane_enable_column_strobe_n <= 1'b1;
            high_lane_enable_column_strobe_n <= 1'b1;
            address_outputs <= '0;
            data_lines_out <= '0;
            data_lines_oe_n <= 1'b1;
            rsp <= '0;
            req_ready <= 1'b0;
        end else begin
            boot_region_select_n <= next_boot_n;
            select_or_row_strobe_n <= next_sel_n;
            write_strobe_n <= next_we_n;
            output_enable_n <= next_oe_n;
            low_lane_enable_column_strobe_n <= next_ble_n;
            high_lane_enable_column_strobe_n <= next_bhe_n;
            address_outputs <= next_addr;
            data_lines_out <= next_dout;
            data_lines_oe_n <= next_doe_n;
            rsp <= next_rsp;
            req_ready <= next_ready;
        end
    end
endmodule

// ---- ext_bus_pkg.sv ----
// Package of constants and carrier types for the external memory bus pins
package ext_bus_pkg;
    localparam int ADDR_W = 24;
    localparam int PIN_ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int NUM_SEL = 5;
    localparam int DRAM_ADDR_LSB = 7;
    localparam int DRAM_ADDR_MSB = 17;
    localparam logic [ADDR_W-1:0] BOOT_BASE_RESET = 24'h000000;
    localparam logic [ADDR_W-1:0] BOOT_MASK_RESET = 24'hF00000;
    localparam logic SEL_ENABLE_RESET = 1'b0;
    localparam logic SWAP_RESET = 1'b0;
    localparam logic CLK_OUT_EN_RESET = 1'b1;
    localparam int DRAM_COL_SHIFT = 11;

    typedef struct packed {
        logic enable;
        logic row_strobe_mode;
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] mask;
    } select_cfg_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [1:0] lanes;
        logic [DATA_W-1:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic done;
        logic [DATA_W-1:0] rdata;
    } bus_rsp_type;
endpackage

// ---- region_decode.sv ----
// Region decoder that picks at most one chip select for an address
`timescale 1ns/1ps
module region_decode
    import ext_bus_pkg::*;
(
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [ADDR_W-1:0] boot_base,
    input wire logic [ADDR_W-1:0] boot_mask,
    input wire logic swap,
    input wire select_cfg_type [NUM_SEL-1:0] cfg,
    output logic boot_hit,
    output logic [NUM_SEL-1:0] sel_hit
);
    function automatic logic in_region(input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] b, input logic [ADDR_W-1:0] m);
        in_region = ((a ^ b) & m) == '0;
    endfunction

    // Select 0 first when swap is set, then boot, then selects in order; one winner only
    always_comb begin
        logic taken;
        taken = 1'b0;
        sel_hit = '0;
        boot_hit = 1'b0;
        if (swap) begin
            if (cfg[0].enable && in_region(addr, cfg[0].base, cfg[0].mask)) begin
                sel_hit[0] = 1'b1;
                taken = 1'b1;
            end
        end
        if (!taken && in_region(addr, boot_base, boot_mask)) begin
            boot_hit = 1'b1;
            taken = 1'b1;
        end
        for (int i = 0; i < NUM_SEL; i++) begin
            if (!taken && cfg[i].enable &&
                in_region(addr, cfg[i].base, cfg[i].mask)) begin
                sel_hit[i] = 1'b1;
                taken = 1'b1;
            end
        end
    end
endmodule

// ---- clock_out_gate.sv ----
// Registered divider that rebuilds the CPU clock image on the clock pin
`timescale 1ns/1ps
module clock_out_gate (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic enable,
    output logic clk_pin
);
    logic next_clk_pin;

    always_comb begin
        next_clk_pin = enable ? ~clk_pin : 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clk_pin <= 1'b0;
        end else begin
            clk_pin <= next_clk_pin;
        end
    end
endmodule

// ---- bus_pins_props.sv ----
// Concurrent checks on the external memory bus pin controller
`timescale 1ns/1ps
module bus_pins_props
    import ext_bus_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire ext_bus_pkg::bus_req_type req,
    input wire ext_bus_pkg::bus_rsp_type rsp,
    input wire logic req_ready,
    input wire ext_bus_pkg::select_cfg_type [ext_bus_pkg::NUM_SEL-1:0] sel_cfg,
    input wire logic clk_out_enable,
    input wire logic boot_is_16bit,
    input wire logic boot_region_select_n,
    input wire logic [ext_bus_pkg::NUM_SEL-1:0] select_or_row_strobe_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic low_lane_enable_column_strobe_n,
    input wire logic buffered_cpu_clock_pin,
    input wire logic [ext_bus_pkg::PIN_ADDR_W-1:0] address_outputs
);
    logic [NUM_SEL-1:0] en;
    logic take;
    always_comb begin
        for (int i = 0; i < NUM_SEL; i++) begin
            en[i] = sel_cfg[i].enable;
        end
    end
    assign take = req.valid && req_ready;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_wr; take && req.write |-> ##[1:2] !write_strobe_n;
    endproperty
    a_wr: assert property (p_wr) else $error("write strobe");
    property p_rd; take && !req.write |-> ##[1:2] !output_enable_n;
    endproperty
    a_rd: assert property (p_rd) else $error("read strobe");
    property p_wroe; write_strobe_n || output_enable_n; endproperty
    a_wroe: assert property (p_wroe) else $error("both strobes");
    property p_lane; $fell(low_lane_enable_column_strobe_n)
        |-> !write_strobe_n || !output_enable_n; endproperty
    a_lane: assert property (p_lane) else $error("lane strobe");
    property p_one;
        $onehot0(~{select_or_row_strobe_n, boot_region_select_n}); endproperty
    a_one: assert property (p_one) else $error("two selects");
    property p_off; &(select_or_row_strobe_n | en); endproperty
    a_off: assert property (p_off) else $error("disabled select");
    property p_done; take |=> !rsp.done ##[1:40] rsp.done; endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_addr; take |=> !boot_region_select_n
        |-> address_outputs == $past(req.addr[19:0]); endproperty
    a_addr: assert property (p_addr) else $error("address");
    property p_ck; clk_out_enable |=> buffered_cpu_clock_pin
        != $past(buffered_cpu_clock_pin); endproperty
    a_ck: assert property (p_ck) else $error("clock pin");
    property p_ckoff; !clk_out_enable |=> !buffered_cpu_clock_pin; endproperty
    a_ckoff: assert property (p_ckoff) else $error("clock off");
    property p_w; $past(rst, 2) == 1'b0 |-> $stable(boot_is_16bit); endproperty
    a_w: assert property (p_w) else $error("width changed");
endmodule
bind external_memory_bus_pins bus_pins_props u_props (.clk_sys, .rst, .req,
    .rsp, .req_ready, .sel_cfg, .clk_out_enable, .boot_is_16bit,
    .boot_region_select_n, .select_or_row_strobe_n, .write_strobe_n,
    .output_enable_n, .low_lane_enable_column_strobe_n,
    .buffered_cpu_clock_pin, .address_outputs);

// ---- ext_mem_model.sv ----
// Behavioural external memory with width strap and wait stretching
`timescale 1ns/1ps
module ext_mem_model
    import ext_bus_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic boot_wide,
    input wire logic [3:0] wait_cycles,
    input wire logic [ext_bus_pkg::PIN_ADDR_W-1:0] address_outputs,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [ext_bus_pkg::DATA_W-1:0] data_lines_out,
    input wire logic data_lines_oe_n,
    output logic [ext_bus_pkg::DATA_W-1:0] data_lines_in,
    output logic wait_or_boot_width_input,
    output logic [ext_bus_pkg::DATA_W-1:0] wr_data
);
    logic [3:0] cnt;
    logic [DATA_W-1:0] last;
    logic act;
    assign act = !output_enable_n || !write_strobe_n;
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt <= 4'h0;
            last <= 16'h0;
        end else begin
            cnt <= act ? cnt + 4'h1 : 4'h0;
            last <= data_lines_in;
            if (!write_strobe_n && !data_lines_oe_n) wr_data <= data_lines_out;
        end
    end
    // Strap pull outside strobes, wait count from strobe (OE or WE) start
    assign wait_or_boot_width_input = act ? (cnt < wait_cycles)
        : boot_wide;
    // Released bus shows a changing pattern
    assign data_lines_in = output_enable_n ? ~last : ~address_outputs[15:0];
endmodule

// ---- testbench.sv ----
// Self-checking bench for the external memory bus pin controller
`timescale 1ns/1ps
module testbench;
    import ext_bus_pkg::*;
    logic clk_sys, rst, swap, clk_out_enable, boot_wide, req_ready, cp;
    logic boot_is_16bit, wait_or_boot_width_input, boot_region_select_n;
    logic write_strobe_n, output_enable_n, low_lane_enable_column_strobe_n;
    logic high_lane_enable_column_strobe_n, buffered_cpu_clock_pin;
    logic data_lines_oe_n;
    bus_req_type req;
    bus_rsp_type rsp;
    select_cfg_type [NUM_SEL-1:0] sel_cfg;
    logic [ADDR_W-1:0] boot_base;
    logic [3:0] wait_cycles;
    logic [NUM_SEL-1:0] select_or_row_strobe_n;
    logic [PIN_ADDR_W-1:0] address_outputs, a1, a2;
    logic [DATA_W-1:0] data_lines_in, data_lines_out, wr_data, rdata;
    logic [9:0] seen;
    int err_count, cmp_count, len;
    external_memory_bus_pins DUT (.clk_sys, .rst, .req, .rsp, .req_ready,
        .boot_base, .swap, .sel_cfg, .clk_out_enable, .boot_is_16bit,
        .wait_or_boot_width_input, .boot_region_select_n,
        .select_or_row_strobe_n, .write_strobe_n, .output_enable_n,
        .low_lane_enable_column_strobe_n, .high_lane_enable_column_strobe_n,
        .buffered_cpu_clock_pin, .address_outputs, .data_lines_in,
        .data_lines_out, .data_lines_oe_n);
    ext_mem_model mem (.clk_sys, .rst, .boot_wide, .wait_cycles,
        .address_outputs, .write_strobe_n, .output_enable_n, .data_lines_out,
        .data_lines_oe_n, .data_lines_in, .wait_or_boot_width_input, .wr_data);
    task automatic chk(input string n, input logic [23:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic access(input logic w, input logic [23:0] a,
            input logic [1:0] ln, input logic [15:0] wd);
        int i;
        req = '{1'b1, w, a, ln, wd};
        seen = '0;
        for (i = 0; i < 50 && !req_ready; i++) @(negedge clk_sys);
        @(negedge clk_sys);
        req.valid = 1'b0;
        for (len = 1; len < 50; len++) begin
            seen |= ~{boot_region_select_n, select_or_row_strobe_n,
                write_strobe_n, output_enable_n,
                low_lane_enable_column_strobe_n,
                high_lane_enable_column_strobe_n};
            if (len == 1) a1 = address_outputs;
            if (len == 2) a2 = address_outputs;
            if (rsp.done === 1'b1) break;
            @(negedge clk_sys);
        end
        rdata = rsp.rdata;
        chk("done", 1'b1, rsp.done);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        err_count++;
        close_out;
    end
    initial begin
        rst = 1'b1;
        req = '0;
        sel_cfg = '0;
        boot_base = 24'h000000;
        swap = 1'b0;
        clk_out_enable = 1'b1;
        boot_wide = 1'b1;
        wait_cycles = 4'h2;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("width", 1'b1, boot_is_16bit);
        chk("idle", 6'h3F, {boot_region_select_n, select_or_row_strobe_n});
        access(0, 24'h000123, 2'b11, 16'h0);
        chk("read", 10'h207, seen);
        chk("addr", 24'h00123, a1);
        chk("rdata", 16'hFEDC, rdata);
        chk("stretch", 1'b1, len >= 4);
        wait_cycles = 4'h0;
        access(1, 24'h000200, 2'b01, 16'h5A3C);
        chk("low wr", 10'h20A, seen);
        chk("wdata", 16'h5A3C, wr_data);
        access(1, 24'h000202, 2'b10, 16'hC3A5);
        chk("high wr", 10'h209, seen);
        boot_base = 24'h300000;
        access(0, 24'h300010, 2'b11, 16'h0);
        chk("moved", 10'h207, seen);
        access(0, 24'h000010, 2'b11, 16'h0);
        chk("nosel", 6'h00, seen[9:4]);
        sel_cfg[1] = '{1'b1, 1'b0, 24'h800000, 24'hF00000};
        sel_cfg[3] = '{1'b1, 1'b1, 24'hA00000, 24'hF00000};
        access(0, 24'h812345, 2'b11, 16'h0);
        chk("sel2", 10'h027, seen);
        chk("sel2 addr", 24'h12345, a1);
        access(1, 24'hA12344, 2'b11, 16'h1234);
        chk("dram", 10'h08B, seen);
        chk("row", 11'h509, a1[17:7]);
        chk("col", 11'h0D1, a2[17:7]);
        sel_cfg[0] = '{1'b1, 1'b0, 24'hF00000, 24'hF00000};
        access(0, 24'hF00008, 2'b11, 16'h0);
        chk("sel1 high", 10'h017, seen);
        sel_cfg[0].base = 24'h000000;
        boot_base = 24'h000000;
        swap = 1'b1;
        access(0, 24'h000040, 2'b11, 16'h0);
        chk("swap", 10'h017, seen);
        access(0, 24'h812345, 2'b11, 16'h0);
        chk("swap sel2", 10'h027, seen);
        clk_out_enable = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("clk off", 1'b0, buffered_cpu_clock_pin);
        clk_out_enable = 1'b1;
        repeat (2) @(negedge clk_sys);
        cp = buffered_cpu_clock_pin;
        @(negedge clk_sys);
        chk("clk on", !cp, buffered_cpu_clock_pin);
        boot_wide = 1'b0;
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("rst out", 4'hF, {write_strobe_n, output_enable_n,
            low_lane_enable_column_strobe_n, data_lines_oe_n});
        rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("width8", 1'b0, boot_is_16bit);
        close_out;
    end
endmodule
